// *** rtl/sdc_ctrl.sv ***
// Purpose: Configuration state, timing registers and direct commands of an SDRAM controller.
// Assumes: Inputs synchronous to I_CLK; software writes arrive as one-cycle strobes.
// Notes:   One clock; scheduler fields counted on the same clock as the bus.
//
// Behaviour
// - PHY write latency is fixed at zero, not programmable.
// - Registers reset to usable defaults.
// - CAS-latency value 0x6 means latency of three memory cycles.
// - Activate timing 0x15 gives delay 5 and scheduler 2.
// - Refresh timing 0x1F2 gives delay 18 and scheduler 15.
// - Refresh period 0xA60 refreshes every 2656 cycles.
// - Chip map matches upper address byte; 0x22FF maps chip at 0x22.
// - Memory config 0xD0020 selects 8 columns, 11 rows, A10, burst 4.
// - Go command moves controller from configuration to Ready.
// - Status reads b01 once memory accesses are accepted.
// - Direct commands decode NOP, precharge-all and auto refresh to chip.
// - Direct 0x80032 sends mode-register-set carrying 0x32.
// - Supports row closing, power-down, clock stop and self-refresh.
// - Read-data-enable timing resets to 3 and is writable in configuration.
// - Status reads b10 when paused, b00 in configuration.
// - Scheduler delays count bus clock cycles.
`timescale 1ns/1ps
module sdc_ctrl #(
	parameter int ADDR_W = 32
) (
	// Clock and reset
	input  wire logic              I_CLK,
	input  wire logic              I_RESET,
	// Configuration writes
	input  wire logic              I_CAS_WR,
	input  wire logic              I_T_RCD_WR,
	input  wire logic              I_T_RFC_WR,
	input  wire logic              I_REFRESH_WR,
	input  wire logic              I_CHIP_MAP_WR,
	input  wire logic [1:0]        I_CHIP_SEL,
	input  wire logic              I_MEMORY_CFG_WR,
	input  wire logic              I_RDDATA_EN_WR,
	input  wire logic              I_DIRECT_WR,
	input  wire logic              I_CTL_CMD_WR,
	input  wire logic [31:0]       I_WDATA,
	// Memory access requests
	input  wire logic              I_ACC_REQ,
	input  wire logic [ADDR_W-1:0] I_ACC_ADDR,
	// Status and decoded configuration
	output logic [1:0]             O_STATUS,
	output logic [2:0]             O_CAS_CYCLES,
	output logic [2:0]             O_T_RCD,
	output logic [2:0]             O_SCHED_RCD,
	output logic [4:0]             O_T_RFC,
	output logic [4:0]             O_SCHED_RFC,
	output logic [3:0]             O_COL_BITS,
	output logic [4:0]             O_ROW_BITS,
	output logic                   O_AP_A10,
	output logic [2:0]             O_BURST,
	output logic                   O_AUTO_PD,
	output logic                   O_STOP_CLK,
	output logic                   O_FORCE_PRE,
	output logic                   O_AUTO_SREF,
	output logic [3:0]             O_PHY_WRLAT,
	output logic [3:0]             O_RDDATA_EN,
	// Memory command output
	output logic                   O_CMD_VALID,
	output logic [1:0]             O_CMD_TYPE,
	output logic [1:0]             O_CMD_CHIP,
	output logic [13:0]            O_CMD_ADDR,
	output logic                   O_REFRESH_DUE,
	output logic                   O_ACC_ISSUE,
	output logic [1:0]             O_ACC_CHIP,
	output logic                   O_ACC_HIT
);

	// ==========================================================
	// Registers
	// ==========================================================
	sdc_pkg::sdc_state_t state;
	sdc_pkg::sdc_state_t next_state;
	logic [31:0] cas_latency;
	logic [31:0] t_rcd;
	logic [31:0] t_rfc;
	logic [31:0] refresh_prd;
	logic [31:0] memory_cfg;
	logic [31:0] rddata_en;
	logic [31:0] chip_map [4];
	logic [14:0] refresh_cnt;

	// ==========================================================
	// Controller state machine
	// ==========================================================
	wire logic [2:0] ctl_cmd = I_WDATA[2:0];

	always_comb begin
		next_state = state;
		if (I_CTL_CMD_WR) begin
			unique case (state)
				sdc_pkg::SDC_CONFIG: begin
					if (ctl_cmd == sdc_pkg::CTL_GO) next_state = sdc_pkg::SDC_READY;
				end
				sdc_pkg::SDC_READY: begin
					if (ctl_cmd == sdc_pkg::CTL_PAUSE) next_state = sdc_pkg::SDC_PAUSED;
				end
				sdc_pkg::SDC_PAUSED: begin
					if (ctl_cmd == sdc_pkg::CTL_GO) next_state = sdc_pkg::SDC_READY;
					else if (ctl_cmd == sdc_pkg::CTL_CONFIGURE) next_state = sdc_pkg::SDC_CONFIG;
				end
				default: next_state = sdc_pkg::SDC_CONFIG;
			endcase
		end
	end

	always_ff @(posedge I_CLK) begin
		if (I_RESET) state <= sdc_pkg::SDC_CONFIG;
		else state <= next_state;
	end

	// ==========================================================
	// Configuration registers
	// ==========================================================
	// Configuration writes only land in the configuration state.
	wire logic cfg_ok = (state == sdc_pkg::SDC_CONFIG);

	always_ff @(posedge I_CLK) begin
		if (I_RESET) begin
			cas_latency <= sdc_pkg::RST_CAS_LATENCY;
			t_rcd       <= sdc_pkg::RST_T_RCD;
			t_rfc       <= sdc_pkg::RST_T_RFC;
			refresh_prd <= sdc_pkg::RST_REFRESH_PRD;
			memory_cfg  <= sdc_pkg::RST_MEMORY_CFG;
			rddata_en   <= sdc_pkg::RST_RDDATA_EN;
		end else if (cfg_ok) begin
			if (I_CAS_WR) cas_latency <= I_WDATA;
			if (I_T_RCD_WR) t_rcd <= I_WDATA;
			if (I_T_RFC_WR) t_rfc <= I_WDATA;
			if (I_REFRESH_WR) refresh_prd <= I_WDATA;
			if (I_MEMORY_CFG_WR) memory_cfg <= I_WDATA;
			if (I_RDDATA_EN_WR) rddata_en <= I_WDATA;
		end
	end

	generate
		for (genvar c = 0; c < 4; c++) begin : g_map
			always_ff @(posedge I_CLK) begin
				if (I_RESET) chip_map[c] <= (c == 0) ? sdc_pkg::RST_CHIP0_MAP : sdc_pkg::RST_CHIP1_MAP;
				else if (cfg_ok && I_CHIP_MAP_WR && I_CHIP_SEL == 2'(c)) chip_map[c] <= I_WDATA;
			end
		end
	endgenerate

	// ==========================================================
	// Field decode
	// ==========================================================
	// Latency in whole cycles
	wire logic [2:0] cas_cycles = cas_latency[3:1];
	wire logic [2:0] rcd_mem = t_rcd[2:0];
	wire logic [2:0] rcd_sch = t_rcd[5:3];
	wire logic [4:0] rfc_mem = t_rfc[4:0];
	wire logic [4:0] rfc_sch = t_rfc[9:5];
	wire logic [3:0] col_bits = 4'(sdc_pkg::COL_BASE) + {1'b0, memory_cfg[sdc_pkg::MCFG_COL_LSB +: 3]};
	wire logic [4:0] row_bits = 5'(sdc_pkg::ROW_BASE) + {3'b0, memory_cfg[sdc_pkg::MCFG_ROW_LSB +: 2]};
	wire logic [2:0] burst    = memory_cfg[sdc_pkg::MCFG_BURST_LSB +: 3];

	// ==========================================================
	// Direct command and access issue
	// ==========================================================
	// Upper byte chip match
	logic [3:0] hit;
	generate
		for (genvar c = 0; c < 4; c++) begin : g_hit
			assign hit[c] = (I_ACC_ADDR[ADDR_W-1 -: 8] == chip_map[c][15:8]);
		end
	endgenerate
	wire logic [1:0] hit_chip = hit[0] ? 2'h0 : hit[1] ? 2'h1 : hit[2] ? 2'h2 : 2'h3;
	wire logic       any_hit  = |hit;
	wire logic acc_go = I_ACC_REQ && any_hit && (state == sdc_pkg::SDC_READY);

	always_ff @(posedge I_CLK) begin
		if (I_RESET) begin
			O_CMD_VALID <= 1'b0;
			O_CMD_TYPE  <= sdc_pkg::DCMD_NOP;
			O_CMD_CHIP  <= 2'h0;
			O_CMD_ADDR  <= 14'h0000;
			O_ACC_ISSUE <= 1'b0;
			O_ACC_CHIP  <= 2'h0;
			O_ACC_HIT   <= 1'b0;
		end else begin
			O_CMD_VALID <= I_DIRECT_WR && cfg_ok;
			O_CMD_TYPE  <= I_WDATA[sdc_pkg::DCMD_TYPE_LSB +: 2];
			O_CMD_CHIP  <= I_WDATA[sdc_pkg::DCMD_CHIP_LSB +: 2];
			O_CMD_ADDR  <= I_WDATA[13:0];
			O_ACC_ISSUE <= acc_go;
			O_ACC_CHIP  <= hit_chip;
			O_ACC_HIT   <= any_hit;
		end
	end

	// ==========================================================
	// Refresh timer
	// ==========================================================
	// Periodic refresh
	always_ff @(posedge I_CLK) begin
		if (I_RESET || state != sdc_pkg::SDC_READY) begin
			refresh_cnt   <= 15'h0000;
			O_REFRESH_DUE <= 1'b0;
		end else if (refresh_cnt >= refresh_prd[14:0] - 15'h0001) begin
			refresh_cnt   <= 15'h0000;
			O_REFRESH_DUE <= 1'b1;
		end else begin
			refresh_cnt   <= refresh_cnt + 15'h0001;
			O_REFRESH_DUE <= 1'b0;
		end
	end

	// ==========================================================
	// Registered outputs
	// ==========================================================
	always_ff @(posedge I_CLK) begin
		if (I_RESET) begin
			O_STATUS     <= 2'h0;
			O_CAS_CYCLES <= 3'h0;
			O_T_RCD      <= 3'h0;
			O_SCHED_RCD  <= 3'h0;
			O_T_RFC      <= 5'h00;
			O_SCHED_RFC  <= 5'h00;
			O_COL_BITS   <= 4'h0;
			O_ROW_BITS   <= 5'h00;
			O_AP_A10     <= 1'b0;
			O_BURST      <= 3'h0;
			O_AUTO_PD    <= 1'b0;
			O_STOP_CLK   <= 1'b0;
			O_FORCE_PRE  <= 1'b0;
			O_AUTO_SREF  <= 1'b0;
			O_PHY_WRLAT  <= sdc_pkg::PHY_WRLAT;
			O_RDDATA_EN  <= 4'h0;
		end else begin
			O_STATUS     <= state;
			O_CAS_CYCLES <= cas_cycles;
			O_T_RCD      <= rcd_mem;
			O_SCHED_RCD  <= rcd_sch;
			O_T_RFC      <= rfc_mem;
			O_SCHED_RFC  <= rfc_sch;
			O_COL_BITS   <= col_bits;
			O_ROW_BITS   <= row_bits;
			O_AP_A10     <= memory_cfg[sdc_pkg::MCFG_AP_BIT];
			O_BURST      <= burst;
			O_AUTO_PD    <= memory_cfg[sdc_pkg::MCFG_APD_BIT];
			O_STOP_CLK   <= memory_cfg[sdc_pkg::MCFG_STOP_BIT];
			O_FORCE_PRE  <= memory_cfg[sdc_pkg::MCFG_FPRE_BIT];
			O_AUTO_SREF  <= memory_cfg[sdc_pkg::MCFG_ASR_BIT];
			O_PHY_WRLAT  <= sdc_pkg::PHY_WRLAT;
			O_RDDATA_EN  <= rddata_en[3:0];
		end
	end

	// ==========================================================
	// Assertions
	// ==========================================================
	sequence s_go_cmd;
		state == sdc_pkg::SDC_CONFIG && I_CTL_CMD_WR && ctl_cmd == sdc_pkg::CTL_GO;
	endsequence
	sequence s_ready_shown;
		state == sdc_pkg::SDC_READY ##1 O_STATUS == 2'h1;
	endsequence
	property p_go;
		@(posedge I_CLK) disable iff (I_RESET) s_go_cmd |=> state == sdc_pkg::SDC_READY;
	endproperty
	a_go: assert property (p_go) else $error("Go did not reach Ready.");

	property p_go_status;
		@(posedge I_CLK) disable iff (I_RESET) s_go_cmd |=> s_ready_shown;
	endproperty
	a_go_status: assert property (p_go_status) else $error("Go did not show Ready status.");

	property p_ready_status;
		@(posedge I_CLK) disable iff (I_RESET)
		(state == sdc_pkg::SDC_READY) |=> O_STATUS == 2'h1;
	endproperty
	a_ready_status: assert property (p_ready_status) else $error("Ready status wrong.");

	property p_paused_status;
		@(posedge I_CLK) disable iff (I_RESET)
		(state == sdc_pkg::SDC_PAUSED) |=> O_STATUS == 2'h2;
	endproperty
	a_paused_status: assert property (p_paused_status) else $error("Paused status wrong.");

	property p_wrlat;
		@(posedge I_CLK) disable iff (I_RESET) ##1 O_PHY_WRLAT == 4'h0;
	endproperty
	a_wrlat: assert property (p_wrlat) else $error("Write latency not zero.");

	property p_no_acc;
		@(posedge I_CLK) disable iff (I_RESET)
		(state != sdc_pkg::SDC_READY) |=> !O_ACC_ISSUE;
	endproperty
	a_no_acc: assert property (p_no_acc) else $error("Access outside Ready.");

	property p_cas;
		@(posedge I_CLK) disable iff (I_RESET)
		(cas_latency == 32'h00000006) |=> O_CAS_CYCLES == 3'h3;
	endproperty
	a_cas: assert property (p_cas) else $error("CAS latency decode wrong.");

	property p_rcd;
		@(posedge I_CLK) disable iff (I_RESET)
		(t_rcd == 32'h00000015) |=> (O_T_RCD == 3'h5 && O_SCHED_RCD == 3'h2);
	endproperty
	a_rcd: assert property (p_rcd) else $error("Activate timing decode wrong.");

	property p_rfc;
		@(posedge I_CLK) disable iff (I_RESET)
		(t_rfc == 32'h000001F2) |=> (O_T_RFC == 5'h12 && O_SCHED_RFC == 5'h0F);
	endproperty
	a_rfc: assert property (p_rfc) else $error("Refresh timing decode wrong.");

	property p_mcfg;
		@(posedge I_CLK) disable iff (I_RESET)
		(memory_cfg == 32'h000D0020) |=> (O_COL_BITS == 4'h8 && O_ROW_BITS == 5'h0B && O_BURST == 3'h2);
	endproperty
	a_mcfg: assert property (p_mcfg) else $error("Memory config decode wrong.");

endmodule : sdc_ctrl

// *** rtl/sdc_pkg.sv ***
// Purpose: Constants for the SDRAM controller configuration and initialization block.
// Assumes: Register port values arrive as 32-bit words on plain ports.
// Notes:   Field positions follow the configuration register layouts.
package sdc_pkg;

	// ==========================================================
	// Controller states and commands
	// ==========================================================
	typedef enum logic [1:0] {
		SDC_CONFIG = 2'h0,
		SDC_READY  = 2'h1,
		SDC_PAUSED = 2'h2
	} sdc_state_t;

	localparam logic [2:0] CTL_GO        = 3'h0;
	localparam logic [2:0] CTL_SLEEP     = 3'h1;
	localparam logic [2:0] CTL_WAKEUP    = 3'h2;
	localparam logic [2:0] CTL_PAUSE     = 3'h3;
	localparam logic [2:0] CTL_CONFIGURE = 3'h4;

	// ==========================================================
	// Direct command encoding
	// ==========================================================
	localparam int DCMD_TYPE_LSB = 18;
	localparam int DCMD_CHIP_LSB = 20;
	localparam logic [1:0] DCMD_PRECHARGE_ALL = 2'h0;
	localparam logic [1:0] DCMD_AUTO_REFRESH  = 2'h1;
	localparam logic [1:0] DCMD_MODE_REG_SET  = 2'h2;
	localparam logic [1:0] DCMD_NOP           = 2'h3;

	// ==========================================================
	// Timing field layouts
	// ==========================================================
	localparam int TIM_MEM_W   = 3;
	localparam int TIM_SCHED_W = 3;
	localparam int TRFC_MEM_W  = 5;
	localparam int TRFC_SCH_W  = 5;

	// ==========================================================
	// Reset values
	// ==========================================================
	localparam logic [31:0] RST_CAS_LATENCY = 32'h00000006;
	localparam logic [31:0] RST_T_RCD       = 32'h00000015;
	localparam logic [31:0] RST_T_RFC       = 32'h000001F2;
	localparam logic [31:0] RST_T_RP        = 32'h00000015;
	localparam logic [31:0] RST_REFRESH_PRD = 32'h00000A60;
	localparam logic [31:0] RST_CHIP0_MAP   = 32'h000000FF;
	localparam logic [31:0] RST_CHIP1_MAP   = 32'h000022FF;
	localparam logic [31:0] RST_MEMORY_CFG  = 32'h000D0020;
	localparam logic [31:0] RST_RDDATA_EN   = 32'h00000003;

	// ==========================================================
	// Memory configuration fields
	// ==========================================================
	localparam int MCFG_COL_LSB    = 0;
	localparam int MCFG_ROW_LSB    = 3;
	localparam int MCFG_AP_BIT     = 5;
	localparam int MCFG_PDP_LSB    = 7;
	localparam int MCFG_APD_BIT    = 13;
	localparam int MCFG_STOP_BIT   = 14;
	localparam int MCFG_BURST_LSB  = 15;
	localparam int MCFG_FPRE_BIT   = 22;
	localparam int MCFG_ASR_BIT    = 23;
	localparam int COL_BASE        = 8;
	localparam int ROW_BASE        = 11;

	// PHY write latency is fixed.
	localparam logic [3:0] PHY_WRLAT = 4'h0;

endpackage : sdc_pkg

// *** sim/sdc_ctrl_tb.sv ***
// Purpose: Self-checking bench for configuration, direct commands and state control.
// Assumes: Inputs change 1 ns after the rising edge; all outputs are registered.
// Notes:   Ordinary direct commands run from a table; other cases are hand-written.
`timescale 1ns/1ps
module sdc_ctrl_tb;
	typedef struct packed {logic [31:0] d; logic [1:0] t; logic [1:0] c; logic [13:0] a;} sdc_row_t;
	logic clk, rst, req, O_CMD_VALID, O_REFRESH_DUE, O_ACC_ISSUE, O_ACC_HIT;
	logic O_AP_A10, O_AUTO_PD, O_STOP_CLK, O_FORCE_PRE, O_AUTO_SREF;
	logic [8:0] stb;
	logic [1:0] sel, O_STATUS, O_CMD_TYPE, O_CMD_CHIP, O_ACC_CHIP;
	logic [31:0] wd, addr;
	logic [31:0] sh [7];
	logic [2:0] O_CAS_CYCLES, O_T_RCD, O_SCHED_RCD, O_BURST;
	logic [4:0] O_T_RFC, O_SCHED_RFC, O_ROW_BITS;
	logic [3:0] O_COL_BITS, O_PHY_WRLAT, O_RDDATA_EN, chip_ready;
	logic [13:0] O_CMD_ADDR;
	logic [3:0][13:0] chip_mode;
	int miscompares, total_checks, n;
	sdc_row_t rows [10] = '{
		'{32'h000C0000, 2'h3, 2'h0, 14'h0000}, '{32'h00000000, 2'h0, 2'h0, 14'h0000},
		'{32'h00040000, 2'h1, 2'h0, 14'h0000}, '{32'h00040000, 2'h1, 2'h0, 14'h0000},
		'{32'h00080032, 2'h2, 2'h0, 14'h0032}, '{32'h001C0000, 2'h3, 2'h1, 14'h0000},
		'{32'h00100000, 2'h0, 2'h1, 14'h0000}, '{32'h00140000, 2'h1, 2'h1, 14'h0000},
		'{32'h00140000, 2'h1, 2'h1, 14'h0000}, '{32'h00183FFF, 2'h2, 2'h1, 14'h3FFF}};
	logic [31:0] acc_a [5] = '{32'h22000010, 32'h00ABCDEF, 32'h55000000, 32'h7FFFFFFF, 32'h99000000};
	logic [3:0]  acc_e [5] = '{4'hD, 4'hC, 4'hE, 4'hF, 4'h0};

	sdc_ctrl i_sdc_ctrl (
		.I_CLK(clk), .I_RESET(rst), .I_CAS_WR(stb[0]), .I_T_RCD_WR(stb[1]), .I_T_RFC_WR(stb[2]),
		.I_REFRESH_WR(stb[3]), .I_CHIP_MAP_WR(stb[4]), .I_CHIP_SEL(sel), .I_MEMORY_CFG_WR(stb[5]),
		.I_RDDATA_EN_WR(stb[6]), .I_DIRECT_WR(stb[7]), .I_CTL_CMD_WR(stb[8]), .I_WDATA(wd),
		.I_ACC_REQ(req), .I_ACC_ADDR(addr), .O_STATUS(O_STATUS), .O_CAS_CYCLES(O_CAS_CYCLES),
		.O_T_RCD(O_T_RCD), .O_SCHED_RCD(O_SCHED_RCD), .O_T_RFC(O_T_RFC), .O_SCHED_RFC(O_SCHED_RFC),
		.O_COL_BITS(O_COL_BITS), .O_ROW_BITS(O_ROW_BITS), .O_AP_A10(O_AP_A10), .O_BURST(O_BURST),
		.O_AUTO_PD(O_AUTO_PD), .O_STOP_CLK(O_STOP_CLK), .O_FORCE_PRE(O_FORCE_PRE),
		.O_AUTO_SREF(O_AUTO_SREF), .O_PHY_WRLAT(O_PHY_WRLAT), .O_RDDATA_EN(O_RDDATA_EN),
		.O_CMD_VALID(O_CMD_VALID), .O_CMD_TYPE(O_CMD_TYPE), .O_CMD_CHIP(O_CMD_CHIP),
		.O_CMD_ADDR(O_CMD_ADDR), .O_REFRESH_DUE(O_REFRESH_DUE), .O_ACC_ISSUE(O_ACC_ISSUE),
		.O_ACC_CHIP(O_ACC_CHIP), .O_ACC_HIT(O_ACC_HIT));

	sdc_mem_model i_sdc_mem_model (
		.i_clk(clk), .i_reset(rst), .i_valid(O_CMD_VALID), .i_type(O_CMD_TYPE), .i_chip(O_CMD_CHIP),
		.i_addr(O_CMD_ADDR), .o_ready(chip_ready), .o_mode(chip_mode));

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// ==========================================================
	// Shared tasks
	// ==========================================================
	task automatic summarize;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : summarize

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected at %0t ns: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic tick(input int c);
		repeat (c) @(posedge clk);
		#1;
	endtask : tick

	// Writes one register; the shadow follows only when writes are accepted.
	task automatic wr(input int k, input logic [31:0] d, input logic take);
		stb[k] = 1'b1;
		wd = d;
		tick(1);
		stb = '0;
		if (take && k < 7)
			sh[k] = d;
		tick(2);
	endtask : wr

	task automatic cfg_chk;
		chk(O_CAS_CYCLES, sh[0][3:1]);
		chk({O_SCHED_RCD, O_T_RCD}, sh[1][5:0]);
		chk({O_SCHED_RFC, O_T_RFC}, sh[2][9:0]);
		chk({O_ROW_BITS, O_COL_BITS}, {5'h0B + sh[5][4:3], 4'h8 + sh[5][2:0]});
		chk({O_BURST, O_AP_A10}, {sh[5][17:15], sh[5][5]});
		chk({O_AUTO_SREF, O_FORCE_PRE, O_STOP_CLK, O_AUTO_PD}, {sh[5][23:22], sh[5][14:13]});
		chk(O_RDDATA_EN, sh[6][3:0]);
		chk(O_PHY_WRLAT, 4'h0);
	endtask : cfg_chk

	task automatic defaults;
		sh = '{sdc_pkg::RST_CAS_LATENCY, sdc_pkg::RST_T_RCD, sdc_pkg::RST_T_RFC, sdc_pkg::RST_REFRESH_PRD,
			sdc_pkg::RST_CHIP1_MAP, sdc_pkg::RST_MEMORY_CFG, sdc_pkg::RST_RDDATA_EN};
		chk(O_STATUS, 2'h0);
		chk(O_CAS_CYCLES, 3'h3);
		chk({O_T_RCD, O_SCHED_RCD, O_T_RFC, O_SCHED_RFC}, {3'h5, 3'h2, 5'h12, 5'h0F});
		chk({O_COL_BITS, O_ROW_BITS, O_AP_A10, O_BURST}, {4'h8, 5'h0B, 1'b1, 3'h2});
		chk({O_AUTO_PD, O_STOP_CLK, O_FORCE_PRE, O_AUTO_SREF}, 4'h0);
		cfg_chk();
	endtask : defaults

	task automatic ctl(input logic [2:0] c, input logic [1:0] e);
		stb[8] = 1'b1;
		wd = {29'h0, c};
		tick(1);
		stb = '0;
		for (n = 0; n < 4 && O_STATUS !== e; n++)
			tick(1);
		chk(O_STATUS, e);
	endtask : ctl

	task automatic await_pulse(input logic refresh, input int lim);
		for (n = 0; (refresh ? O_REFRESH_DUE : O_CMD_VALID) !== 1'b1; n++) begin
			if (n >= lim) begin
				miscompares++;
				summarize();
			end
			tick(1);
		end
	endtask : await_pulse

	task automatic access(input logic [31:0] a, input logic [3:0] e);
		addr = a;
		req = 1'b1;
		tick(3);
		chk(O_ACC_ISSUE, e[2]);
		chk(O_ACC_HIT, e[3]);
		if (e[2])
			chk(O_ACC_CHIP, e[1:0]);
		req = 1'b0;
		tick(1);
	endtask : access

	// ==========================================================
	// Main sequence
	// ==========================================================
	initial begin
		{rst, stb, sel, wd, req, addr} = '0;
		rst = 1'b1;
		miscompares = 0;
		total_checks = 0;
		tick(3);
		rst = 1'b0;
		tick(2);
		defaults();
		wr(0, 32'h00000004, 1'b1);
		wr(1, 32'h0000002C, 1'b1);
		wr(2, 32'h000003E7, 1'b1);
		wr(5, 32'h00C27A43, 1'b1);
		wr(6, 32'h0000000F, 1'b1);
		cfg_chk();
		sel = 2'h2;
		wr(4, 32'h000055FF, 1'b1);
		sel = 2'h3;
		wr(4, 32'h00007FFF, 1'b1);
		// Direct commands initialize chip 0 then chip 1.
		for (int i = 0; i < 10; i++) begin
			stb[7] = 1'b1;
			wd = rows[i].d;
			tick(1);
			stb = '0;
			await_pulse(1'b0, 4);
			chk({O_CMD_TYPE, O_CMD_CHIP, O_CMD_ADDR}, {rows[i].t, rows[i].c, rows[i].a});
			tick(1);
		end
		tick(2);
		chk({chip_ready[1:0], chip_mode[0], chip_mode[1]}, {2'h3, 14'h0032, 14'h3FFF});
		access(32'h22000010, 4'h8);
		ctl(sdc_pkg::CTL_GO, 2'h1);
		for (int i = 0; i < 5; i++)
			access(acc_a[i], acc_e[i]);
		// Writes outside configuration are ignored.
		wr(0, 32'h00000002, 1'b0);
		stb[7] = 1'b1;
		wd = 32'h000C0000;
		tick(1);
		stb = '0;
		for (n = 0; n < 4; n++) begin
			chk(O_CMD_VALID, 1'b0);
			tick(1);
		end
		cfg_chk();
		await_pulse(1'b1, 6000);
		tick(1);
		await_pulse(1'b1, 6000);
		chk(n + 1, 2656);
		ctl(sdc_pkg::CTL_PAUSE, 2'h2);
		access(32'h22000010, 4'h8);
		ctl(sdc_pkg::CTL_GO, 2'h1);
		ctl(sdc_pkg::CTL_PAUSE, 2'h2);
		ctl(sdc_pkg::CTL_CONFIGURE, 2'h0);
		wr(0, 32'h00000006, 1'b1);
		cfg_chk();
		rst = 1'b1;
		tick(3);
		rst = 1'b0;
		tick(2);
		defaults();
		summarize();
	end
endmodule : sdc_ctrl_tb

// *** sim/sdc_mem_model.sv ***
// Purpose: Behavioural model of the memory chips that receive direct commands.
// Assumes: One command per cycle of i_valid; chip number selects one of four chips.
// Notes:   A chip counts as initialized after NOP, precharge-all, two refreshes and a mode set.
`timescale 1ns/1ps
module sdc_mem_model (
	// Clock and reset
	input  wire logic             i_clk,
	input  wire logic             i_reset,
	// Command from the controller
	input  wire logic             i_valid,
	input  wire logic [1:0]       i_type,
	input  wire logic [1:0]       i_chip,
	input  wire logic [13:0]      i_addr,
	// Chip state
	output logic [3:0]            o_ready,
	output logic [3:0][13:0]      o_mode
);
	// ==========================================================
	// Initialization progress per chip
	// ==========================================================
	logic [3:0][2:0] step;
	logic [2:0]      cur;
	logic [2:0]      next_step;
	assign cur = step[i_chip];
	assign next_step = (i_type == 2'h3) ? 3'h1 :
		(i_type == 2'h0 && cur == 3'h1) ? 3'h2 :
		(i_type == 2'h1 && (cur == 3'h2 || cur == 3'h3)) ? cur + 3'h1 :
		(i_type == 2'h2 && cur == 3'h4) ? 3'h5 : 3'h0;
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			step <= '0;
			o_mode <= '0;
		end else if (i_valid) begin
			step[i_chip] <= next_step;
			if (i_type == 2'h2)
				o_mode[i_chip] <= i_addr;
		end
	end
	always_comb begin
		for (int c = 0; c < 4; c++)
			o_ready[c] = (step[c] == 3'h5);
	end
endmodule : sdc_mem_model
